// ==== verilog/fault_manager_defines.vh ====
// Register offsets, field positions, reset values and timing counts of the fault manager
`ifndef FAULT_MANAGER_DEFINES_VH
`define FAULT_MANAGER_DEFINES_VH
// Register indices as printed; byte address is four times the index
`define IDX_WARN_STATUS   4'h1
`define IDX_OCP_STATUS    4'h2
`define IDX_FAULT_STATUS  4'h3
`define IDX_LS_DRIVE_CTRL 4'h5
`define IDX_HS_DRIVE_CTRL 4'h6
`define IDX_PROT_CTRL     4'h9
`define IDX_OC_CTRL       4'hc
`define IDX_VDS_STATUS    4'h4
// Warning status fields
`define WARN_FAULT_BIT    10
`define WARN_SUP_LOW_BIT  7
`define WARN_SUP_HIGH_BIT 6
`define WARN_PUMP_LOW_BIT 5
`define WARN_VDS_BIT      4
`define WARN_THERMAL_BIT  0
// Fault status fields
`define FLT_SUP_LOCK_BIT  10
`define FLT_THERMAL_BIT   8
`define FLT_GATE_BIT      7
`define FLT_ANALOG_BIT    5
`define FLT_LOWGATE_BIT   4
`define FLT_PUMP_UV_BIT   2
`define FLT_PUMP_ABS_BIT  1
`define FLT_PUMP_REL_BIT  0
// Control fields
`define DRIVE_TIME_LSB    8
`define GATE_CHK_DIS_BIT  8
`define LOCK_DIS_BIT      9
`define CLR_FAULTS_BIT    1
`define OC_MODE_LSB       0
// Overcurrent response modes
`define OC_MODE_LATCH     3'h0
`define OC_MODE_REPORT    3'h1
`define OC_MODE_DISABLED  3'h2
// Reset values
`define DRIVE_CTRL_RESET  11'h300
`define PROT_CTRL_RESET   11'h000
`define OC_CTRL_RESET     11'h000
// Warning blink half period and drive timer base
`define BLINK_HALF_US     56
`define CLK_MHZ           10
`define BLINK_HALF_CYC    (`BLINK_HALF_US * `CLK_MHZ)
`define DRIVE_BASE_CYC    8'h0a
`define STRONG_PD_CYC     8'h05
`endif

// ==== verilog/motor_predriver_fault_manager.v ====
// Fault and warning supervisor for a three-phase predriver, with APB registers
`timescale 1ns/1ns
`include "fault_manager_defines.vh"
module motor_predriver_fault_manager #(
  parameter PHASES = 3
) (
  input  wire                clk,
  input  wire                nrst,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [7:0]          paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire                gate_enable,
  input  wire [2*PHASES-1:0] gate_command,
  input  wire [2*PHASES-1:0] gate_sense,
  input  wire [2*PHASES-1:0] drain_source_overcurrent,
  input  wire [PHASES-1:0]   source_overcurrent,
  input  wire                main_supply_lockout,
  input  wire                main_supply_low_warning,
  input  wire                main_supply_high_warning,
  input  wire                pump_relative_overvoltage,
  input  wire                pump_absolute_overvoltage,
  input  wire                pump_undervoltage,
  input  wire                pump_low_warning,
  input  wire                low_gate_supply_undervoltage,
  input  wire                analog_supply_undervoltage,
  input  wire                thermal_warning,
  input  wire                thermal_shutdown,
  output reg  [2*PHASES-1:0] gate_out,
  output reg  [2*PHASES-1:0] strong_pulldown,
  output reg                 drivers_enabled,
  output reg                 fault_indicator_pin_out,
  output reg                 fault_indicator_pin_oe_n
);
  localparam NMON = 2*PHASES + PHASES + 12;
  localparam NW = 6;

  // Two-flop synchronisers on every analog monitor output
  wire [NMON-1:0] mon_raw = {drain_source_overcurrent, source_overcurrent,
    main_supply_lockout, main_supply_low_warning, main_supply_high_warning,
    pump_relative_overvoltage, pump_absolute_overvoltage, pump_undervoltage,
    pump_low_warning, low_gate_supply_undervoltage, analog_supply_undervoltage,
    thermal_warning, thermal_shutdown, 1'b0};
  reg [NMON-1:0] sync1_reg;
  reg [NMON-1:0] sync2_reg;
  always @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= {NMON{1'b0}};
      sync2_reg <= {NMON{1'b0}};
    end else begin
      sync1_reg <= mon_raw;
      sync2_reg <= sync1_reg;
    end
  end
  wire [2*PHASES-1:0] vds_s  = sync2_reg[NMON-1 -: 2*PHASES];
  // Bit 0 is the spare pad, so singles start at bit 1
  wire [PHASES-1:0]   sns_s  = sync2_reg[PHASES+11 -: PHASES];
  wire lock_s   = sync2_reg[11];
  wire low_s    = sync2_reg[10];
  wire high_s   = sync2_reg[9];
  wire prel_s   = sync2_reg[8];
  wire pabs_s   = sync2_reg[7];
  wire puv_s    = sync2_reg[6];
  wire plow_s   = sync2_reg[5];
  wire lguv_s   = sync2_reg[4];
  wire avuv_s   = sync2_reg[3];
  wire otw_s    = sync2_reg[2];
  wire thermal_shutdown_s   = sync2_reg[1];

  // Control registers
  reg  [10:0] ls_ctrl_reg;
  reg  [10:0] hs_ctrl_reg;
  reg  [10:0] prot_ctrl_reg;
  reg  [10:0] oc_ctrl_reg;
  wire [2:0]  oc_mode   = oc_ctrl_reg[`OC_MODE_LSB +: 3];
  wire        chk_dis   = prot_ctrl_reg[`GATE_CHK_DIS_BIT];
  wire        lock_dis  = prot_ctrl_reg[`LOCK_DIS_BIT];
  wire        clr_req   = prot_ctrl_reg[`CLR_FAULTS_BIT];

  // APB decode; all accesses complete with pready in the access cycle
  wire        acc   = psel & penable;
  wire [3:0]  idx   = paddr[5:2];
  wire        wr    = acc & pwrite;
  wire        rd    = acc & ~pwrite;
  wire        known = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) &&
                      ((idx >= `IDX_WARN_STATUS && idx <= `IDX_HS_DRIVE_CTRL) ||
                       idx == `IDX_PROT_CTRL || idx == `IDX_OC_CTRL);

  // Overcurrent classification by mode
  wire vds_any    = |vds_s && (oc_mode != `OC_MODE_DISABLED);
  wire vds_latch  = vds_any && (oc_mode == `OC_MODE_LATCH);
  wire vds_report = vds_any && (oc_mode == `OC_MODE_REPORT);

  // Latched fault set conditions; lockout disable only blocks the shutdown
  reg  [10:0] fault_reg;
  reg  [2*PHASES-1:0] vds_flt_reg;
  reg  [PHASES-1:0]   sns_reg;
  reg  [2*PHASES-1:0] mismatch_reg;
  reg                 lock_shut_reg;
  reg                 vds_latch_reg;
  wire shut = lock_shut_reg | (|sns_reg) | (|mismatch_reg) |
              (|fault_reg[`FLT_THERMAL_BIT:0] & ~fault_reg[`FLT_THERMAL_BIT-2]) |
              (vds_latch_reg);
  wire causes_gone = ~(lock_s | prel_s | pabs_s | puv_s | lguv_s | avuv_s | thermal_shutdown_s |
                       (|sns_s) | (|vds_s));
  reg  en_d_reg;
  wire en_rise = gate_enable & ~en_d_reg;
  wire clear_now = (clr_req | en_rise) & causes_gone;

  // Gate drive timer, its length picked per side
  reg  [7:0]  drv_cnt_reg [0:2*PHASES-1];
  reg  [2*PHASES-1:0] cmd_d_reg;
  wire [7:0]  ls_len = {4'h0, ls_ctrl_reg[`DRIVE_TIME_LSB +: 2], 2'b00} + `DRIVE_BASE_CYC;
  wire [7:0]  hs_len = {4'h0, hs_ctrl_reg[`DRIVE_TIME_LSB +: 2], 2'b00} + `DRIVE_BASE_CYC;
  genvar g;
  generate
    for (g = 0; g < 2*PHASES; g = g + 1) begin : gate_chk
      // Even index low side, odd index high side
      wire [7:0] len  = (g % 2 == 1) ? hs_len : ls_len;
      // Partner side runs its own length, so its timer is judged by it
      wire [7:0] plen = (g % 2 == 1) ? ls_len : hs_len;
      always @(posedge clk) begin
        if (!nrst) begin
          drv_cnt_reg[g] <= 8'h00;
          mismatch_reg[g] <= 1'b0;
        end else begin
          if (gate_command[g] != cmd_d_reg[g])
            drv_cnt_reg[g] <= len;
          else if (drv_cnt_reg[g] != 8'h00)
            drv_cnt_reg[g] <= drv_cnt_reg[g] - 8'h01;
          // Compare only when the timer runs out
          if (drv_cnt_reg[g] == 8'h01 && drivers_enabled && !chk_dis &&
              gate_sense[g] != gate_out[g])
            mismatch_reg[g] <= 1'b1;
          else if (clear_now)
            mismatch_reg[g] <= 1'b0;
        end
      end
      // Strong pulldown on the off gate while its partner turns on
      always @(posedge clk) begin
        if (!nrst)
          strong_pulldown[g] <= 1'b0;
        else
          strong_pulldown[g] <= !gate_out[g] && gate_command[g^1] &&
                                (drv_cnt_reg[g^1] > plen - `STRONG_PD_CYC);
      end
    end
  endgenerate

  // Status latching; set wins over clear except on the gate bit, which clear_now zeroes
  always @(posedge clk) begin
    if (!nrst) begin
      fault_reg     <= 11'h000;
      vds_flt_reg   <= {2*PHASES{1'b0}};
      sns_reg       <= {PHASES{1'b0}};
      lock_shut_reg <= 1'b0;
      vds_latch_reg <= 1'b0;
      en_d_reg      <= 1'b0;
      cmd_d_reg     <= {2*PHASES{1'b0}};
    end else begin
      en_d_reg  <= gate_enable;
      cmd_d_reg <= gate_command;
      fault_reg[`FLT_SUP_LOCK_BIT] <= lock_s | (fault_reg[`FLT_SUP_LOCK_BIT] & ~clear_now);
      lock_shut_reg <= (lock_s & ~lock_dis) | (lock_shut_reg & ~clear_now);
      fault_reg[`FLT_THERMAL_BIT] <= thermal_shutdown_s | (fault_reg[`FLT_THERMAL_BIT] & ~clear_now);
      fault_reg[`FLT_GATE_BIT]    <= (|mismatch_reg) & ~clear_now;
      fault_reg[`FLT_ANALOG_BIT]  <= avuv_s | (fault_reg[`FLT_ANALOG_BIT] & ~clear_now);
      fault_reg[`FLT_LOWGATE_BIT] <= lguv_s | (fault_reg[`FLT_LOWGATE_BIT] & ~clear_now);
      fault_reg[`FLT_PUMP_UV_BIT] <= puv_s | (fault_reg[`FLT_PUMP_UV_BIT] & ~clear_now);
      fault_reg[`FLT_PUMP_ABS_BIT] <= pabs_s | (fault_reg[`FLT_PUMP_ABS_BIT] & ~clear_now);
      fault_reg[`FLT_PUMP_REL_BIT] <= prel_s | (fault_reg[`FLT_PUMP_REL_BIT] & ~clear_now);
      fault_reg[9] <= 1'b0;
      fault_reg[6] <= 1'b0;
      fault_reg[3] <= 1'b0;
      sns_reg <= sns_s | (sns_reg & {PHASES{~clear_now}});
      vds_flt_reg <= (vds_any ? vds_s : {2*PHASES{1'b0}}) |
                     (vds_flt_reg & {2*PHASES{~clear_now}});
      vds_latch_reg <= vds_latch | (vds_latch_reg & ~clear_now);
    end
  end

  // Warning sources: level, seen-flag and read acknowledge per source
  wire [NW-1:0] warn_lvl = {vds_report, plow_s, low_s, high_s, otw_s, 1'b0};
  reg  [NW-1:0] warn_ack_reg;
  wire warn_rd = rd && idx == `IDX_WARN_STATUS;
  wire vds_rd  = rd && idx == `IDX_VDS_STATUS;
  always @(posedge clk) begin
    if (!nrst)
      warn_ack_reg <= {NW{1'b0}};
    else
      // Ack drops when condition passes, so a reoccurrence blinks again
      warn_ack_reg <= warn_lvl & (warn_ack_reg |
        {vds_rd, {NW-1{warn_rd}}});
  end
  wire warn_pending = |(warn_lvl & ~warn_ack_reg);

  // Blink divider: toggles every 56 us while a warning is pending
  reg [9:0] blink_cnt_reg;
  reg       blink_reg;
  always @(posedge clk) begin
    if (!nrst || !warn_pending) begin
      blink_cnt_reg <= 10'h000;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg == `BLINK_HALF_CYC - 1) begin
      blink_cnt_reg <= 10'h000;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 10'h001;
    end
  end
  wire any_fault = |fault_reg | (|sns_reg) | vds_latch_reg;

  // Outputs: fault holds pin low, warning blinks, else released
  always @(posedge clk) begin
    if (!nrst) begin
      drivers_enabled          <= 1'b0;
      gate_out                 <= {2*PHASES{1'b0}};
      fault_indicator_pin_out  <= 1'b0;
      fault_indicator_pin_oe_n <= 1'b1;
    end else begin
      drivers_enabled <= gate_enable & ~shut;
      gate_out <= (gate_enable & ~shut) ? gate_command : {2*PHASES{1'b0}};
      fault_indicator_pin_out  <= 1'b0;
      fault_indicator_pin_oe_n <= ~(any_fault | (warn_pending & ~blink_reg));
    end
  end

  // Register writes; clear bit self-clears once faults are cleared
  always @(posedge clk) begin
    if (!nrst) begin
      ls_ctrl_reg   <= `DRIVE_CTRL_RESET;
      hs_ctrl_reg   <= `DRIVE_CTRL_RESET;
      prot_ctrl_reg <= `PROT_CTRL_RESET;
      oc_ctrl_reg   <= `OC_CTRL_RESET;
    end else begin
      if (wr && idx == `IDX_LS_DRIVE_CTRL && known)
        ls_ctrl_reg <= pwdata[10:0];
      if (wr && idx == `IDX_HS_DRIVE_CTRL && known)
        hs_ctrl_reg <= pwdata[10:0];
      if (wr && idx == `IDX_OC_CTRL && known)
        oc_ctrl_reg <= pwdata[10:0];
      if (wr && idx == `IDX_PROT_CTRL && known)
        prot_ctrl_reg <= pwdata[10:0];
      else if (clear_now)
        prot_ctrl_reg[`CLR_FAULTS_BIT] <= 1'b0;
    end
  end

  // Read mux and zero-wait-state answer
  reg [10:0] rd_val;
  always @* begin
    case (idx)
      `IDX_WARN_STATUS:   rd_val = {any_fault, 2'b00, low_s, high_s, plow_s,
                                    vds_report, 3'b000, otw_s};
      `IDX_OCP_STATUS:    rd_val = {{11-PHASES{1'b0}}, sns_reg};
      `IDX_FAULT_STATUS:  rd_val = fault_reg;
      `IDX_VDS_STATUS:    rd_val = {{11-2*PHASES{1'b0}}, vds_flt_reg};
      `IDX_LS_DRIVE_CTRL: rd_val = ls_ctrl_reg;
      `IDX_HS_DRIVE_CTRL: rd_val = hs_ctrl_reg;
      `IDX_PROT_CTRL:     rd_val = prot_ctrl_reg;
      `IDX_OC_CTRL:       rd_val = oc_ctrl_reg;
      default:            rd_val = 11'h000;
    endcase
  end
  always @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~known;
      prdata  <= (psel & ~penable & ~pwrite & known) ? {21'h000000, rd_val} : 32'h0000_0000;
    end
  end
endmodule // motor_predriver_fault_manager

// ==== bench/fault_manager_monitor.sv ====
// Port checker for the fault manager, bound to its top module
`timescale 1ns/1ns
module fault_manager_monitor #(parameter PHASES = 3) (
  input logic                clk,
  input logic                nrst,
  input logic                psel,
  input logic                penable,
  input logic                pready,
  input logic                pslverr,
  input logic [2*PHASES-1:0] gate_command,
  input logic [2*PHASES-1:0] gate_out,
  input logic                drivers_enabled,
  input logic [PHASES-1:0]   source_overcurrent,
  input logic                pump_undervoltage,
  input logic                fault_indicator_pin_out,
  input logic                fault_indicator_pin_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Bus cycle steps
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; psel && penable && pready; endsequence
  setup_answered_a: assert property (setup_s |=> answer_s) else $error("setup not answered");
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  error_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  // Open drain, so the data side never drives high
  pin_drives_low_a: assert property (!fault_indicator_pin_out) else $error("pin high");
  gate_follows_a: assert property (gate_out != 0 |-> gate_out == $past(gate_command))
    else $error("gate not commanded");
  // Six cycles cover the sync flops and the latch
  source_trip_a: assert property ((|source_overcurrent) [*6] |->
    gate_out == 0 && !fault_indicator_pin_oe_n) else $error("source trip missed");
  pump_trip_a: assert property (pump_undervoltage [*6] |->
    !drivers_enabled && gate_out == 0) else $error("pump trip missed");
  sync_delay_a: assert property ($rose(pump_undervoltage) && drivers_enabled
    |=> drivers_enabled) else $error("monitor not synchronised");
endmodule // fault_manager_monitor
bind motor_predriver_fault_manager fault_manager_monitor #(.PHASES(PHASES)) mon (
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .gate_command(gate_command), .gate_out(gate_out),
  .drivers_enabled(drivers_enabled), .source_overcurrent(source_overcurrent),
  .pump_undervoltage(pump_undervoltage), .fault_indicator_pin_out(fault_indicator_pin_out),
  .fault_indicator_pin_oe_n(fault_indicator_pin_oe_n));

// ==== bench/gate_stage_model.sv ====
// Far side model: gate stage with stuck gates and pulled-up fault line
`timescale 1ns/1ns
module gate_stage_model (
  input  logic [5:0] gate_out,
  input  logic [5:0] stuck_mask,
  input  logic       pin_out,
  input  logic       pin_oe_n,
  output logic [5:0] gate_sense,
  output logic       fault_line
);
  // A shorted gate reads low whatever is driven
  assign gate_sense = gate_out & ~stuck_mask;
  // Pull-up wins when released, so idle reads high
  assign fault_line = pin_oe_n ? 1'b1 : pin_out;
endmodule // gate_stage_model

// ==== bench/motor_predriver_fault_manager_tb.sv ====
// Self-checking bench: APB tasks, monitor stimulus and port checks
`timescale 1ns/1ns
module motor_predriver_fault_manager_tb;
  logic        clk, nrst, psel, penable, pwrite, gate_enable;
  logic        pready, pslverr, er, pin_out, pin_oe_n, drv_en, fline;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  cmd, gsense, gout, spd, dso, stuck;
  logic [2:0]  so;
  logic [6:0]  fv;
  logic [3:0]  wv;
  int          err_total, comparisons, i;
  int          fb[10] = '{0, 1, 2, 4, 10, 5, 8, 0, 1, 2};
  int          wb[4] = '{7, 6, 5, 0};
  motor_predriver_fault_manager uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gate_enable(gate_enable), .gate_command(cmd), .gate_sense(gsense),
    .drain_source_overcurrent(dso), .source_overcurrent(so), .main_supply_lockout(fv[4]),
    .main_supply_low_warning(wv[0]), .main_supply_high_warning(wv[1]),
    .pump_relative_overvoltage(fv[0]), .pump_absolute_overvoltage(fv[1]),
    .pump_undervoltage(fv[2]), .pump_low_warning(wv[2]), .low_gate_supply_undervoltage(fv[3]),
    .analog_supply_undervoltage(fv[5]), .thermal_warning(wv[3]), .thermal_shutdown(fv[6]),
    .gate_out(gout), .strong_pulldown(spd), .drivers_enabled(drv_en),
    .fault_indicator_pin_out(pin_out), .fault_indicator_pin_oe_n(pin_oe_n));
  gate_stage_model far (.gate_out(gout), .stuck_mask(stuck), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .gate_sense(gsense), .fault_line(fline));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Clear request waits for the latch and gates to settle
  task automatic clr;
    apb(1'b1, 8'h24, 32'h2);
    cyc(3);
  endtask
  task automatic final_report;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run is near 5200 cycles
  initial begin
    #3000000;
    err_total++;
    final_report;
  end
  initial begin
    {nrst, psel, penable, pwrite, gate_enable} = 5'h0;
    {paddr, pwdata, cmd, dso, stuck, so, fv, wv} = 0;
    cyc(20);
    nrst <= 1'b1;
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 8'h14 + 8'(i * 4) + ((i == 2) ? 8'h8 : ((i == 3) ? 8'h10 : 8'h0)), 32'h0);
      chk("reset value", (i < 2) ? 32'h300 : 32'h0, rd);
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", 32'h1, er);
    chk("idle line", 32'h1, fline);
    gate_enable <= 1'b1;
    cmd <= 6'h15;
    cyc(4);
    chk("gates run", 32'h15, gout);
    $display("done: reset");
    for (i = 0; i < 4; i++) begin
      wv <= 4'(1 << i);
      cyc(6);
      chk("warn gates", 32'h15, gout);
      chk("warn low", 32'h0, fline);
      cyc(560);
      chk("warn high", 32'h1, fline);
      apb(1'b0, 8'h04, 32'h0);
      chk("warn bit", 32'h1, (rd >> wb[i]) & 1);
      cyc(600);
      chk("warn acked", 32'h1, fline);
      wv <= 4'h0;
      cyc(4);
    end
    $display("done: warnings");
    apb(1'b1, 8'h24, 32'h200);
    fv <= 7'h10;
    cyc(6);
    chk("lockout masked", 32'h15, gout);
    apb(1'b0, 8'h0c, 32'h0);
    chk("lockout bit", 32'h1, (rd >> 10) & 1);
    fv <= 7'h0;
    cyc(4);
    clr;
    for (i = 0; i < 10; i++) begin
      if (i < 7) fv <= 7'(1 << i);
      else so <= 3'(1 << (i - 7));
      cyc(6);
      chk("fault gates", 32'h0, gout);
      chk("fault line", 32'h0, fline);
      apb(1'b0, (i < 7) ? 8'h0c : 8'h08, 32'h0);
      chk("fault bit", 32'h1, (rd >> fb[i]) & 1);
      clr;
      chk("fault held", 32'h0, gout);
      {fv, so} <= 10'h0;
      cyc(6);
      clr;
      chk("fault cleared", 32'h15, gout);
    end
    $display("done: faults");
    for (i = 2; i >= 0; i--) begin
      apb(1'b1, 8'h30, 32'(i));
      dso <= 6'h04;
      cyc(6);
      chk("oc gates", (i == 0) ? 32'h0 : 32'h15, gout);
      chk("oc line", (i == 2) ? 32'h1 : 32'h0, fline);
      apb(1'b0, 8'h10, 32'h0);
      chk("oc status", (i == 2) ? 32'h0 : 32'h4, rd);
      dso <= 6'h0;
      cyc(4);
      clr;
    end
    $display("done: overcurrent");
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk("low time", 32'h0, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("high time", 32'h300, rd);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, 8'h24, i ? 32'h0 : 32'h100);
      cmd <= 6'h0;
      cyc(4);
      stuck <= 6'h01;
      cmd <= 6'h15;
      cyc(3);
      chk("strong pulldown", 32'h2a, spd);
      cyc(27);
      apb(1'b0, 8'h0c, 32'h0);
      chk("gate check bit", 32'(i), (rd >> 7) & 1);
      chk("gate check out", i ? 32'h0 : 32'h15, gout);
      stuck <= 6'h0;
      cyc(4);
      clr;
    end
    $display("done: gate check");
    final_report;
  end
endmodule // motor_predriver_fault_manager_tb
